// *** src/srs_supervisor.sv ***
/*
 * Decision logic of a compact safety relay: input options, reset modes,
 * feedback supervision, short detection, status and indicator.
 * Assumes contact levels arrive as logic levels (1 = closed or live),
 * with short detectors and a supply monitor provided by the analog front.
 */
`include "srs_defs.svh"

// Operation
// - Five input options selectable: single, dual NO, NO+NC, rails, safety mat.
// - Energise both relays only with inputs active and reset complete.
// - De-energise both relays on input deactivation or supply failure.
// - Refuse reset unless relays one and two read back de-energised.
// - Drive a changeover status output reporting relay state.
// - Manual reset needs reset contact closed then opened; stuck closed never activates.
// - Dual NO, NO+NC and rails options check both inputs before allowing reset.
// - Flash on indicator at low supply or actuated safety mat.
// - Single channel: first input closed to activate, open drops outputs.
// - Dual NO: both inputs closed to activate, either opening drops outputs.
// - Dual NO: new reset only after both contacts opened and reclosed.
// - NO+NC: NO closed, NC open to activate; change or short drops outputs.
// - NO+NC: reactivate only after both inputs returned to initial state.
// - Rails option acts like dual NO and drops outputs on rail short.
// - Mat: both contacts made to activate; actuation or short drops, flashes.
// - Auto reset via link; outputs activate together with inputs.
// - Feedback path in series with reset input must be closed to activate.
// - Status output low while not reset, high once reset.
// - Outputs switch within the maximum response time after input change.
module srs_supervisor import srs_pkg::*; #(
    parameter int DEBOUNCE_CYC = `SRS_DEBOUNCE_CYC,
    parameter int RESET_MIN_CYC = `SRS_RESET_MIN_CYC,
    parameter int FLASH_HALF_CYC = `SRS_FLASH_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [2:0] input_option,
    input wire logic first_channel_pos_input,
    input wire logic second_channel_pos_input,
    input wire logic nc_channel_input,
    input wire logic zero_volt_channel_input,
    input wire logic mat_return_terminal,
    input wire logic cross_short_detect,
    input wire logic reset_input,
    input wire logic auto_reset_link,
    input wire logic relay1_open_fb,
    input wire logic relay2_open_fb,
    input wire logic supply_ok,
    input wire logic supply_low,
    output logic relay1_drive,
    output logic relay2_drive,
    output logic status_output,
    output logic on_indicator
);
    localparam int NIN = 8;
    localparam int RW = $clog2(RESET_MIN_CYC + 1);
    localparam int FW = $clog2(FLASH_HALF_CYC + 1);
    localparam int RESP_CYC = `SRS_RESPONSE_MAX_CYC;

    if (RESET_MIN_CYC < 1 || FLASH_HALF_CYC < 1 || DEBOUNCE_CYC < 1) begin : g_bad_counts
        $error("timing counts must be at least one");
    end
    if (DEBOUNCE_CYC + 8 >= RESP_CYC) begin : g_bad_debounce
        $error("debounce too long for the response time");
    end

    // ======================================================================
    // Reset release
    // ======================================================================
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ======================================================================
    // Input conditioning
    // ======================================================================
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] db_in;

    assign raw_in = {reset_input, auto_reset_link, cross_short_detect, mat_return_terminal,
                     zero_volt_channel_input, nc_channel_input, second_channel_pos_input,
                     first_channel_pos_input};

    for (genvar i = 0; i < NIN; i++) begin : g_db
        srs_debounce #(
            .COUNT(DEBOUNCE_CYC)
        ) u_db (
            .sys_clk(sys_clk),
            .rst_n(rst_n_q),
            .clk_en(clk_en),
            .raw(raw_in[i]),
            .clean(db_in[i])
        );
    end

    logic ch1;
    logic ch2;
    logic ch_nc;
    logic ch_0v;
    logic ch_mat;
    logic xshort;
    logic auto_mode;
    logic rst_in;

    assign ch1 = db_in[0];
    assign ch2 = db_in[1];
    assign ch_nc = db_in[2];
    assign ch_0v = db_in[3];
    assign ch_mat = db_in[4];
    assign xshort = db_in[5];
    assign auto_mode = db_in[6];
    assign rst_in = db_in[7];

    // ======================================================================
    // Option decode
    // ======================================================================
    srs_option_t opt;
    logic opt_valid;

    function automatic srs_option_t decode_opt(input logic [2:0] code);
        case (code)
            `SRS_OPT_SINGLE: decode_opt = SRS_SINGLE;
            `SRS_OPT_DUAL_NO: decode_opt = SRS_DUAL_NO;
            `SRS_OPT_NO_NC: decode_opt = SRS_NO_NC;
            `SRS_OPT_RAILS: decode_opt = SRS_RAILS;
            default: decode_opt = SRS_MAT;
        endcase
    endfunction

    assign opt = decode_opt(input_option);
    assign opt_valid = input_option <= `SRS_OPT_MAT;

    // Inputs active for the chosen option, and the fully released rest state
    logic inputs_active;
    logic inputs_idle;
    logic fault_short;

    always_comb begin
        inputs_active = 1'b0;
        inputs_idle = 1'b0;
        fault_short = 1'b0;
        case (opt)
            SRS_SINGLE: begin
                inputs_active = ch1;
                inputs_idle = !ch1;
            end
            SRS_DUAL_NO: begin
                inputs_active = ch1 && ch2;
                inputs_idle = !ch1 && !ch2;
            end
            SRS_NO_NC: begin
                inputs_active = ch1 && !ch_nc;
                inputs_idle = !ch1 && ch_nc;
                fault_short = xshort;
            end
            SRS_RAILS: begin
                inputs_active = ch1 && ch_0v;
                inputs_idle = !ch1 && !ch_0v;
                fault_short = xshort;
            end
            SRS_MAT: begin
                inputs_active = ch1 && ch_mat;
                inputs_idle = 1'b1;
                fault_short = xshort;
            end
            default: begin
                inputs_active = 1'b0;
                inputs_idle = 1'b0;
            end
        endcase
    end

    logic run_ok;
    assign run_ok = inputs_active && !fault_short && supply_ok && opt_valid;

    // ======================================================================
    // Dual channel supervision: both channels must have been released
    // ======================================================================
    srs_state_t state_q;
    logic released_q;

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            released_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == SRS_ST_ON) begin
                released_q <= 1'b0;
            end else if (inputs_idle && !fault_short) begin
                released_q <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Manual reset: closure timed, release completes the reset
    // ======================================================================
    logic rst_prev_q;
    logic [RW-1:0] hold_q;
    logic hold_met;
    logic reset_pulse;
    logic relays_open;

    assign hold_met = hold_q == RW'(RESET_MIN_CYC);
    assign relays_open = relay1_open_fb && relay2_open_fb;

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rst_prev_q <= 1'b0;
            hold_q <= '0;
        end else if (clk_en) begin
            rst_prev_q <= rst_in;
            if (!rst_in) begin
                hold_q <= '0;
            end else if (!hold_met) begin
                hold_q <= hold_q + 1'b1;
            end
        end
    end

    // Falling edge after a long enough closure; a stuck contact never falls
    assign reset_pulse = rst_prev_q && !rst_in && hold_met;

    // ======================================================================
    // Relay state machine
    // ======================================================================
    logic permit;

    // Auto mode: the reset input level is the feedback path, so it must be closed
    assign permit = relays_open && released_q;

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= SRS_ST_OFF;
        end else if (clk_en) begin
            case (state_q)
                SRS_ST_OFF: begin
                    if (!run_ok) begin
                        state_q <= SRS_ST_OFF;
                    end else if (auto_mode) begin
                        if (rst_in && permit) begin
                            state_q <= SRS_ST_ON;
                        end
                    end else if (reset_pulse && permit) begin
                        state_q <= SRS_ST_ON;
                    end
                end
                SRS_ST_ON: begin
                    if (!run_ok) begin
                        state_q <= SRS_ST_OFF;
                    end
                end
                default: state_q <= SRS_ST_OFF;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            relay1_drive <= 1'b0;
            relay2_drive <= 1'b0;
            status_output <= 1'b0;
        end else if (clk_en) begin
            relay1_drive <= state_q == SRS_ST_ON && run_ok;
            relay2_drive <= state_q == SRS_ST_ON && run_ok;
            status_output <= state_q == SRS_ST_ON;
        end
    end

    // ======================================================================
    // On indicator
    // ======================================================================
    logic [FW-1:0] flash_cnt_q;
    logic flash_q;
    logic flash_req;

    assign flash_req = supply_low || (opt == SRS_MAT && (!ch_mat || xshort));

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else if (clk_en) begin
            if (flash_cnt_q == FW'(FLASH_HALF_CYC - 1)) begin
                flash_cnt_q <= '0;
                flash_q <= !flash_q;
            end else begin
                flash_cnt_q <= flash_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            on_indicator <= 1'b0;
        end else if (clk_en) begin
            on_indicator <= flash_req ? flash_q : 1'b1;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    chk_relays_pair: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        relay1_drive == relay2_drive)
        else $error("relay drives differ");

    chk_drop_on_loss: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && !run_ok |=> !relay1_drive)
        else $error("relay held after loss of inputs");

    chk_reset_refused: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && state_q == SRS_ST_OFF && !relays_open |=> state_q == SRS_ST_OFF)
        else $error("reset taken with relay not open");

    chk_status_follows: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en |=> status_output == ($past(state_q) == SRS_ST_ON))
        else $error("status output wrong");

    chk_manual_edge: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && state_q == SRS_ST_OFF && !auto_mode && !reset_pulse
        |=> state_q == SRS_ST_OFF)
        else $error("manual activation without reset release");

    chk_need_release: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && state_q == SRS_ST_OFF && !released_q |=> state_q == SRS_ST_OFF)
        else $error("activation without both channels released");

    chk_feedback: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && state_q == SRS_ST_OFF && auto_mode && !rst_in
        |=> state_q == SRS_ST_OFF)
        else $error("auto activation with feedback open");

    chk_auto_fast: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
        clk_en && state_q == SRS_ST_OFF && auto_mode && rst_in && permit && run_ok
        ##1 clk_en && run_ok |=> relay1_drive)
        else $error("auto mode did not energise");

    cov_manual: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
        !auto_mode && reset_pulse ##1 state_q == SRS_ST_ON);
    cov_auto: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
        auto_mode && state_q == SRS_ST_ON);
    cov_short: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
        state_q == SRS_ST_ON && fault_short);
    cov_flash: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
        flash_req && $fell(on_indicator));
endmodule

// *** src/srs_defs.svh ***
/*
 * Timing counts for the safety relay supervisor.
 * Assumes a 200 MHz system clock (period 5 ns).
 */
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

// ==========================================================================
// Clock and times
// ==========================================================================
`define SRS_CLK_PERIOD_NS 5
`define SRS_RESET_MIN_MS 80
`define SRS_RESPONSE_MAX_MS 20
`define SRS_DEBOUNCE_US 1000
`define SRS_FLASH_HALF_MS 250
`define SRS_RESET_MIN_CYC ((`SRS_RESET_MIN_MS * 1000000 + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_DEBOUNCE_CYC ((`SRS_DEBOUNCE_US * 1000) / `SRS_CLK_PERIOD_NS)
`define SRS_FLASH_HALF_CYC ((`SRS_FLASH_HALF_MS * 1000000) / `SRS_CLK_PERIOD_NS)
`define SRS_RESPONSE_MAX_CYC ((`SRS_RESPONSE_MAX_MS * 1000000) / `SRS_CLK_PERIOD_NS)

// ==========================================================================
// Input option encodings
// ==========================================================================
`define SRS_OPT_SINGLE 3'h0
`define SRS_OPT_DUAL_NO 3'h1
`define SRS_OPT_NO_NC 3'h2
`define SRS_OPT_RAILS 3'h3
`define SRS_OPT_MAT 3'h4

`endif

// *** src/srs_pkg.sv ***
/*
 * Types of the safety relay supervisor.
 * Assumes nothing of its surroundings.
 */
package srs_pkg;

// ==========================================================================
// Types
// ==========================================================================
typedef enum logic [2:0] {
    SRS_SINGLE,
    SRS_DUAL_NO,
    SRS_NO_NC,
    SRS_RAILS,
    SRS_MAT
} srs_option_t;

typedef enum logic [1:0] {
    SRS_ST_OFF,
    SRS_ST_ARMED,
    SRS_ST_ON
} srs_state_t;

endpackage

// *** src/srs_debounce.sv ***
/*
 * Debouncer: a two-flop synchroniser then a stability counter.
 * Assumes the input level is asynchronous contact state.
 */
`include "srs_defs.svh"

module srs_debounce import srs_pkg::*; #(
    parameter int COUNT = `SRS_DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic raw,
    output logic clean
);
    localparam int CW = $clog2(COUNT + 1);

    if (COUNT < 1) begin : g_bad_count
        $error("debounce count must be at least one");
    end

    logic sync1_q;
    logic sync2_q;
    logic [CW-1:0] cnt_q;

    // ======================================================================
    // Synchroniser
    // ======================================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // ======================================================================
    // Stability filter
    // ======================================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            clean <= 1'b0;
        end else if (clk_en) begin
            if (sync2_q == clean) begin
                cnt_q <= '0;
            end else if (cnt_q == CW'(COUNT - 1)) begin
                cnt_q <= '0;
                clean <= sync2_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// *** verification/srs_field_model.sv ***
/*
 * Field side of the supervisor: relay armatures, external contactor and reset button.
 * Assumes the bench steers the button, the strap and the fault requests.
 */
module srs_field_model (
    input wire logic sys_clk,
    input wire logic relay1_drive,
    input wire logic relay2_drive,
    input wire logic button,
    input wire logic auto_mode,
    input wire logic weld_fault,
    input wire logic contactor_stuck,
    output logic reset_input,
    output logic auto_reset_link,
    output logic relay1_open_fb,
    output logic relay2_open_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] arm1_q;
    logic [1:0] arm2_q;
    logic contactor_q;
    // ==========================================================================
    // Armatures follow the coils two cycles late; a weld holds relay one shut
    // ==========================================================================
    always_ff @(posedge sys_clk) begin
        arm1_q <= {arm1_q[0], relay1_drive | weld_fault};
        arm2_q <= {arm2_q[0], relay2_drive};
        contactor_q <= (relay1_drive & relay2_drive) | contactor_stuck;
    end
    assign relay1_open_fb = ~arm1_q[1];
    assign relay2_open_fb = ~arm2_q[1];
    // ==========================================================================
    // Contactor rest contact in series with the button or the strap
    // ==========================================================================
    assign reset_input = (button | auto_mode) & ~contactor_q;
    assign auto_reset_link = auto_mode;
endmodule

// *** verification/test_safety_relay_supervisor.sv ***
/*
 * Self-checking bench of the safety relay supervisor with shortened counts.
 * Assumes the field model answers for relays, contactor and reset button.
 */
`include "srs_defs.svh"

module test_safety_relay_supervisor import srs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, clk_en, ch1, ch2, nc, zv, mat, xshort, sup_ok, sup_low;
    logic [2:0] opt;
    logic button, auto_mode, weld, stuck, run;
    logic reset_input, auto_link, fb1, fb2, r1, r2, status_output, on_indicator;
    logic [2:0] notes[$];
    logic [31:0] seed;
    int fail_count, n_tests, tog;

    srs_supervisor #(.DEBOUNCE_CYC(4), .RESET_MIN_CYC(8), .FLASH_HALF_CYC(4))
    i_srs_supervisor (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .input_option(opt), .first_channel_pos_input(ch1), .second_channel_pos_input(ch2),
        .nc_channel_input(nc), .zero_volt_channel_input(zv), .mat_return_terminal(mat),
        .cross_short_detect(xshort), .reset_input(reset_input),
        .auto_reset_link(auto_link), .relay1_open_fb(fb1), .relay2_open_fb(fb2),
        .supply_ok(sup_ok), .supply_low(sup_low), .relay1_drive(r1), .relay2_drive(r2),
        .status_output(status_output), .on_indicator(on_indicator));

    srs_field_model i_srs_field_model (.sys_clk(sys_clk), .relay1_drive(r1),
        .relay2_drive(r2), .button(button), .auto_mode(auto_mode), .weld_fault(weld),
        .contactor_stuck(stuck), .reset_input(reset_input), .auto_reset_link(auto_link),
        .relay1_open_fb(fb1), .relay2_open_fb(fb2));

    always #2.5 sys_clk = ~sys_clk;

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic press();
        seed = xs(seed);
        button = 1'b1;
        cyc(12 + int'(seed[2:0]));
        button = 1'b0;
        cyc(20);
    endtask

    // Note the expected relay and status levels, then wait for the change;
    // with a press the note goes first, as the relays close during the press
    task automatic expect_out(input logic [2:0] e, input bit do_press = 1'b0);
        int i;
        notes.push_back(e);
        if (do_press) press();
        for (i = 0; i < 30 && r1 !== e[2]; i++) cyc(1);
        if (r1 !== e[2]) begin
            void'(notes.pop_back());
            cmp({7'h0, r1}, {7'h0, e[2]});
        end
        cyc(4);
    endtask

    task automatic refused();
        cmp({6'h0, r1, r2}, 8'h00);
    endtask

    task automatic flashes();
        logic prev;
        prev = on_indicator;
        tog = 0;
        repeat (40) begin
            cyc(1);
            if (on_indicator !== prev) tog++;
            prev = on_indicator;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================================
    // Output watcher
    // ==========================================================================
    initial forever begin
        @(r1);
        if (run) begin
            cyc(2);
            cmp({5'h0, r1, r2, status_output},
                notes.size() > 0 ? {5'h0, notes.pop_front()} : 8'hff);
        end
    end

    initial begin
        cyc(20000);
        fail_count++;
        $display("TIMEOUT at %0t", $time);
        complete_run();
    end

    // ==========================================================================
    // Tests
    // ==========================================================================
    initial begin
        sys_clk = 0; reset_n = 0; clk_en = 1; opt = `SRS_OPT_SINGLE;
        {ch1, ch2, zv, mat, xshort, sup_low, button, auto_mode, weld, stuck, run} = '0;
        nc = 1; sup_ok = 1; seed = 32'ha82f0dfa;
        cyc(6);
        reset_n = 1'b1;
        cyc(20);
        run = 1'b1;
        ch1 = 1; cyc(20);
        button = 1; cyc(4); button = 0; cyc(20); refused();
        button = 1; cyc(40); refused();
        button = 0; expect_out(3'h7);
        ch1 = 0; expect_out(3'h0);
        $display("test single done");
        opt = `SRS_OPT_DUAL_NO; ch1 = 1; ch2 = 1; cyc(20);
        expect_out(3'h7, 1'b1); cmp({7'h0, r1}, 8'h01);
        ch2 = 0; expect_out(3'h0);
        ch2 = 1; cyc(20); press(); refused();
        {ch1, ch2} = 2'b00; cyc(20); {ch1, ch2} = 2'b11; cyc(20);
        expect_out(3'h7, 1'b1);
        sup_ok = 0; expect_out(3'h0);
        sup_ok = 1; {ch1, ch2} = 2'b00; cyc(20);
        $display("test dual done");
        opt = `SRS_OPT_NO_NC; cyc(20); ch1 = 1; nc = 0; cyc(20);
        expect_out(3'h7, 1'b1);
        xshort = 1; expect_out(3'h0);
        xshort = 0; cyc(20); press(); refused();
        ch1 = 0; nc = 1; cyc(20); ch1 = 1; nc = 0; cyc(20);
        expect_out(3'h7, 1'b1);
        nc = 1; expect_out(3'h0);
        ch1 = 0; cyc(20);
        $display("test no_nc done");
        opt = `SRS_OPT_RAILS; cyc(20); ch1 = 1; zv = 1; cyc(20);
        expect_out(3'h7, 1'b1);
        xshort = 1; expect_out(3'h0);
        xshort = 0; ch1 = 0; zv = 0; cyc(20);
        $display("test rails done");
        opt = `SRS_OPT_MAT; ch1 = 1; mat = 1; cyc(20);
        expect_out(3'h7, 1'b1);
        flashes(); cmp(8'(tog), 8'h00);
        mat = 0; expect_out(3'h0);
        flashes(); cmp({7'h0, tog > 1}, 8'h01);
        mat = 1; cyc(20); expect_out(3'h7, 1'b1);
        xshort = 1; expect_out(3'h0);
        xshort = 0; ch1 = 0; cyc(20);
        $display("test mat done");
        opt = `SRS_OPT_SINGLE; ch1 = 1; cyc(20);
        weld = 1; cyc(20); press(); refused();
        weld = 0; stuck = 1; cyc(20); press(); refused();
        stuck = 0; cyc(20); expect_out(3'h7, 1'b1);
        sup_low = 1; flashes(); cmp({7'h0, tog > 1}, 8'h01);
        sup_low = 0; clk_en = 0; ch1 = 0; cyc(20); cmp({7'h0, r1}, 8'h01);
        clk_en = 1; expect_out(3'h0);
        $display("test feedback done");
        auto_mode = 1; cyc(20); ch1 = 1; expect_out(3'h7);
        ch1 = 0; expect_out(3'h0);
        stuck = 1; cyc(20); ch1 = 1; cyc(30); refused();
        ch1 = 0; cyc(20); stuck = 0; auto_mode = 0; cyc(20);
        $display("test auto done");
        repeat (4) begin
            seed = xs(seed);
            opt = 3'h5 + 3'(seed[1:0] % 3);
            {ch1, ch2, nc, zv, mat} = seed[8:4];
            cyc(20); press(); refused();
        end
        $display("test invalid done");
        complete_run();
    end
endmodule
